// File: core/ckod_top.sv
// AHB-Lite register bank configuring two differential clock output drivers.
//
// Local design decision: register access over AHB-Lite.
module ckod_top
    import ckod_pkg::*;
#(
    parameter int NUM_OUT = 2
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Driver cell controls and shared clock source.
    output ckod_ctrl_s drv_ctrl [NUM_OUT],
    output ckod_src_e clk_source
);

    ////////////////////////////////////////////////////////////////////////
    // Address phase capture.

    logic wr_pend;
    logic [31:0] wr_addr;
    logic next_wr_pend;
    logic [31:0] next_wr_addr;
    logic addr_phase;

    always_comb begin
        addr_phase = hsel && htrans[1] && hready;
        next_wr_pend = addr_phase && hwrite;
        next_wr_addr = addr_phase ? haddr : wr_addr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers, one per output plus the source select.

    ckod_cfg_s cfg [NUM_OUT];
    ckod_cfg_s next_cfg [NUM_OUT];
    ckod_ctrl_s dec_ctrl [NUM_OUT];
    ckod_src_e src;
    ckod_src_e next_src;
    logic [31:0] out_addr [NUM_OUT];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            // Each output has its own word; only its own driver is steered.
            assign out_addr[gi] = CKOD_OUT0_ADDR + 32'(gi * 4); // RQ7

            always_comb begin
                next_cfg[gi] = cfg[gi];
                if (wr_pend && (wr_addr == out_addr[gi])) begin
                    next_cfg[gi].full_swing =
                        hwdata[CKOD_SWING_BIT]; // RQ1
                    next_cfg[gi].format = ckod_fmt_e'(
                        hwdata[CKOD_FMT_LSB +: 3]); // RQ3
                    next_cfg[gi].polarity = ckod_pol_e'(
                        hwdata[CKOD_POL_LSB +: 2]); // RQ4
                    next_cfg[gi].drive_low = hwdata[CKOD_DRV_BIT]; // RQ5
                    next_cfg[gi].enable = hwdata[CKOD_EN_BIT]; // RQ6
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cfg[gi] <= ckod_cfg_s'(CKOD_CFG_RESET); // RQ1 RQ3 RQ6
                end else begin
                    cfg[gi] <= next_cfg[gi];
                end
            end

            // Decoding the next value keeps the outputs in step with
            // the register contents.
            ckod_decode u_decode (
                .cfg(next_cfg[gi]),
                .ctrl(dec_ctrl[gi])
            );

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    drv_ctrl[gi] <= CKOD_CTRL_RESET;
                end else begin
                    drv_ctrl[gi] <= dec_ctrl[gi]; // RQ7
                end
            end
        end
    endgenerate

    always_comb begin
        next_src = src;
        if (wr_pend && (wr_addr == CKOD_SRC_ADDR)) begin
            next_src = ckod_src_e'(hwdata[CKOD_SRC_BIT]); // RQ8
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src <= ckod_src_e'(CKOD_SRC_RESET);
            clk_source <= ckod_src_e'(CKOD_SRC_RESET);
        end else begin
            src <= next_src;
            clk_source <= next_src; // RQ8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word built from the decoded driver state.

    logic [31:0] status;

    always_comb begin
        status = 32'h0;
        for (int i = 0; i < NUM_OUT; i++) begin
            status[i * CKOD_STAT_STRIDE + CKOD_STAT_ACTIVE] =
                dec_ctrl[i].pos_on || dec_ctrl[i].neg_on;
            status[i * CKOD_STAT_STRIDE + CKOD_STAT_RSVD] =
                dec_ctrl[i].reserved_format;
            status[i * CKOD_STAT_STRIDE + CKOD_STAT_SWING_IGN] =
                dec_ctrl[i].swing_ignored; // RQ2
        end
        status[CKOD_STAT_SRC_BIT] = next_src;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and response.

    logic [31:0] next_hrdata;

    // Reads use the next register values so a read that directly follows
    // a write to the same word returns the new contents.
    always_comb begin
        next_hrdata = 32'h0;
        if (addr_phase && !hwrite) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (haddr == out_addr[i]) begin
                    next_hrdata = {24'h0, next_cfg[i]};
                end
            end
            if (haddr == CKOD_SRC_ADDR) begin
                next_hrdata[CKOD_SRC_BIT] = next_src;
            end
            if (haddr == CKOD_STAT_ADDR) begin
                next_hrdata = status;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : ckod_top

// File: core/ckod_pkg.sv
// Constants, types and field layout of the clock output driver configuration.
// Function
// [RQ1] Bit 7 selects 1.8 V or full swing.
// [RQ2] Software sets full swing only for CMOS formats.
// [RQ3] Bits 6:4 select driver format, reset 4.
// [RQ4] Bits 3:2 set CMOS leg polarities, reset 00.
// [RQ5] Bit 1 selects drive strength, LVDS/full-swing only.
// [RQ6] Bit 0 enables driver, resets enabled.
// [RQ7] Second register mirrors first, controls second driver.
// [RQ8] Shared source bit: divider or PLL reference.
package ckod_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [11:0] CKOD_SRC_IDX = 12'h241;
    localparam logic [11:0] CKOD_OUT0_IDX = 12'h242;
    localparam logic [11:0] CKOD_OUT1_IDX = 12'h243;
    localparam logic [11:0] CKOD_STAT_IDX = 12'h250;
    localparam logic [31:0] CKOD_SRC_ADDR = {18'h0, CKOD_SRC_IDX, 2'b00};
    localparam logic [31:0] CKOD_OUT0_ADDR = {18'h0, CKOD_OUT0_IDX, 2'b00};
    localparam logic [31:0] CKOD_OUT1_ADDR = {18'h0, CKOD_OUT1_IDX, 2'b00};
    localparam logic [31:0] CKOD_STAT_ADDR = {18'h0, CKOD_STAT_IDX, 2'b00};

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int CKOD_SWING_BIT = 7;
    localparam int CKOD_FMT_LSB = 4;
    localparam int CKOD_POL_LSB = 2;
    localparam int CKOD_DRV_BIT = 1;
    localparam int CKOD_EN_BIT = 0;
    localparam int CKOD_SRC_BIT = 7;
    localparam logic [7:0] CKOD_CFG_RESET = 8'hc1;
    localparam logic CKOD_SRC_RESET = 1'b0;
    // Status layout: one nibble per output, source select above them.
    localparam int CKOD_STAT_STRIDE = 4;
    localparam int CKOD_STAT_ACTIVE = 0;
    localparam int CKOD_STAT_RSVD = 1;
    localparam int CKOD_STAT_SWING_IGN = 2;
    localparam int CKOD_STAT_SRC_BIT = 8;

    ////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [2:0] {
        FMT_TRISTATE = 3'h0,
        FMT_HSTL = 3'h1,
        FMT_LVDS = 3'h2,
        FMT_HCSL = 3'h3,
        FMT_CMOS_BOTH = 3'h4,
        FMT_CMOS_POS = 3'h5,
        FMT_CMOS_NEG = 3'h6,
        FMT_RESERVED = 3'h7
    } ckod_fmt_e;

    typedef enum logic [1:0] {
        POL_NONINV_INV = 2'h0,
        POL_INV_INV = 2'h1,
        POL_NONINV_NONINV = 2'h2,
        POL_INV_NONINV = 2'h3
    } ckod_pol_e;

    typedef enum logic {
        SRC_SHARED_DIVIDER = 1'b0,
        SRC_PLL_REFERENCE = 1'b1
    } ckod_src_e;

    typedef struct packed {
        logic full_swing;
        ckod_fmt_e format;
        ckod_pol_e polarity;
        logic drive_low;
        logic enable;
    } ckod_cfg_s;

    // Decoded controls for one driver cell.
    typedef struct packed {
        logic power_on;
        ckod_fmt_e format;
        logic pos_on;
        logic neg_on;
        logic pos_invert;
        logic neg_invert;
        logic full_swing;
        logic cmos_low_drive;
        logic lvds_high_current;
        logic reserved_format;
        logic swing_ignored;
    } ckod_ctrl_s;

    // Decode of CKOD_CFG_RESET: enabled, CMOS both legs, full swing.
    localparam ckod_ctrl_s CKOD_CTRL_RESET = '{
        power_on: 1'b1, format: FMT_CMOS_BOTH, pos_on: 1'b1, neg_on: 1'b1,
        pos_invert: 1'b0, neg_invert: 1'b1, full_swing: 1'b1,
        cmos_low_drive: 1'b0, lvds_high_current: 1'b0,
        reserved_format: 1'b0, swing_ignored: 1'b0};

endpackage : ckod_pkg

// File: core/ckod_decode.sv
// Field decoder that turns one configuration byte into driver cell controls.
module ckod_decode
    import ckod_pkg::*;
(
    // Configuration byte.
    input wire ckod_cfg_s cfg,
    // Driver cell controls.
    output ckod_ctrl_s ctrl
);

    logic is_cmos;
    logic is_lvds;
    logic legal;

    always_comb begin
        is_cmos = (cfg.format == FMT_CMOS_BOTH) ||
                  (cfg.format == FMT_CMOS_POS) ||
                  (cfg.format == FMT_CMOS_NEG);
        is_lvds = (cfg.format == FMT_LVDS);
        // The reserved code is driven as tristate so the pins stay quiet.
        legal = (cfg.format != FMT_RESERVED);
        ctrl = '0;
        ctrl.power_on = cfg.enable; // RQ6
        ctrl.format = legal ? cfg.format : FMT_TRISTATE; // RQ3
        ctrl.pos_on = cfg.enable && legal &&
                      (cfg.format != FMT_TRISTATE) &&
                      (cfg.format != FMT_CMOS_NEG); // RQ3
        ctrl.neg_on = cfg.enable && legal &&
                      (cfg.format != FMT_TRISTATE) &&
                      (cfg.format != FMT_CMOS_POS); // RQ3
        // Leg inversion only matters for a CMOS driver.
        ctrl.pos_invert = is_cmos && cfg.polarity[0]; // RQ4
        ctrl.neg_invert = is_cmos && !cfg.polarity[1]; // RQ4
        // Full swing is honoured only on CMOS formats.
        ctrl.full_swing = is_cmos && cfg.full_swing; // RQ1 RQ2
        ctrl.cmos_low_drive = is_cmos && cfg.full_swing &&
                              cfg.drive_low; // RQ5
        ctrl.lvds_high_current = is_lvds && cfg.drive_low; // RQ5
        ctrl.reserved_format = !legal;
        ctrl.swing_ignored = cfg.full_swing && !is_cmos;
    end

endmodule : ckod_decode

// File: dv/ckod_top_asserts.sv
// Port assertions for the clock output driver register bank.
module ckod_top_asserts
    import ckod_pkg::*;
#(
    parameter int NUM_OUT = 2
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Driver cell controls and shared clock source.
    input wire ckod_ctrl_s drv_ctrl [NUM_OUT],
    input wire ckod_src_e clk_source
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    // Flags of the transfer whose data phase runs now: read, out0, source.
    logic [2:0] flags;
    logic [2:0] next_flags;
    logic taken;
    assign taken = hsel && htrans[1] && hready;
    always_comb begin
        next_flags[2] = taken && !hwrite;
        next_flags[1] = taken && hwrite && haddr == CKOD_OUT0_ADDR;
        next_flags[0] = taken && hwrite && haddr == CKOD_SRC_ADDR;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= 3'h0;
        end else begin
            flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    ready_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    read_idle_a: assert property (!flags[2] |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    out0_write_a: assert property (flags[1] |=>
        drv_ctrl[0].power_on == $past(hwdata[0]) && $stable(drv_ctrl[1]))
        else $error("first driver write not applied alone");
    src_write_a: assert property (flags[0] |=>
        clk_source == $past(hwdata[7]))
        else $error("source select not applied");
    swing_cmos_a: assert property (drv_ctrl[0].full_swing |->
        drv_ctrl[0].format inside {FMT_CMOS_BOTH, FMT_CMOS_POS, FMT_CMOS_NEG})
        else $error("full swing outside a cmos format");
    legs_fmt_a: assert property (drv_ctrl[0].format == FMT_CMOS_POS |->
        drv_ctrl[0].pos_on == drv_ctrl[0].power_on && !drv_ctrl[0].neg_on)
        else $error("positive only legs wrong");
    power_gate_a: assert property (!drv_ctrl[1].power_on |->
        !drv_ctrl[1].pos_on && !drv_ctrl[1].neg_on)
        else $error("legs active while powered down");
    drive_lvds_a: assert property (drv_ctrl[0].lvds_high_current |->
        drv_ctrl[0].format == FMT_LVDS)
        else $error("lvds current outside lvds");
    pol_cmos_a: assert property (drv_ctrl[1].pos_invert |->
        drv_ctrl[1].format inside {FMT_CMOS_BOTH, FMT_CMOS_POS, FMT_CMOS_NEG})
        else $error("inversion outside a cmos format");
endmodule : ckod_top_asserts

bind ckod_top ckod_top_asserts #(.NUM_OUT(NUM_OUT)) u_asserts (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .drv_ctrl(drv_ctrl), .clk_source(clk_source));

// File: dv/ckod_top_tb.sv
// Self-checking testbench of the clock output driver register bank.
module ckod_top_tb
    import ckod_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic hready, hreadyout, hresp;
    logic [31:0] hrdata;
    ckod_ctrl_s drv_ctrl [2];
    ckod_src_e clk_source;
    int fail_count = 0;
    int compares = 0;
    assign hready = hreadyout;
    always #10 hclk = ~hclk;
    ckod_top #(.NUM_OUT(2)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .drv_ctrl(drv_ctrl), .clk_source(clk_source));

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h, expected %h", $time,
                seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("compares %0d, fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    // One single transfer; read data lands in rd, outputs settle after #1.
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1;
    endtask : bus

    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        check(drv_ctrl[0], CKOD_CTRL_RESET);
        check(drv_ctrl[1], CKOD_CTRL_RESET);
        check(clk_source, SRC_SHARED_DIVIDER);
        bus(1'b0, CKOD_OUT0_ADDR, 32'h0);
        check(rd, 32'hc1);
        bus(1'b0, CKOD_OUT1_ADDR, 32'h0);
        check(rd, 32'hc1);
    endtask : t_reset
    task t_formats;
        logic [31:0] v;
        for (int f = 0; f < 8; f++) begin
            v = {24'h0, f > 3 && f < 7, f[2:0], 4'h3};
            bus(1'b1, CKOD_OUT0_ADDR, v);
            check({drv_ctrl[0].pos_on, drv_ctrl[0].neg_on},
                {f > 0 && f < 6, (f > 0 && f < 5) || f == 6});
            check(drv_ctrl[0].full_swing, f > 3 && f < 7);
            check({drv_ctrl[0].lvds_high_current, drv_ctrl[0]
                .cmos_low_drive}, {f == 2, f > 3 && f < 7});
            check(drv_ctrl[0].reserved_format, f == 7);
            check(drv_ctrl[0].format, f == 7 ? 0 : f);
            check(drv_ctrl[0].swing_ignored, 1'b0);
            check(drv_ctrl[1], CKOD_CTRL_RESET);
            bus(1'b0, CKOD_OUT0_ADDR, 32'h0);
            check(rd, v);
            bus(1'b0, CKOD_STAT_ADDR, 32'h0);
            check(rd, {23'h0, 5'h1, 2'h0, f == 7, f > 0 && f < 7});
        end
    endtask : t_formats
    task t_polarity;
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, CKOD_OUT1_ADDR, {24'h0, 4'hc, p[1:0], 2'h1});
            check({drv_ctrl[1].pos_invert, drv_ctrl[1].neg_invert},
                {p[0], !p[1]});
        end
        bus(1'b1, CKOD_OUT1_ADDR, 32'h40);
        check({drv_ctrl[1].power_on, drv_ctrl[1].pos_on,
            drv_ctrl[1].neg_on}, 3'h0);
        check(drv_ctrl[0].reserved_format, 1'b1);
    endtask : t_polarity
    task t_off_swing;
        bus(1'b1, CKOD_OUT0_ADDR, 32'h42);
        check({drv_ctrl[0].power_on, drv_ctrl[0].pos_on, drv_ctrl[0].neg_on,
            drv_ctrl[0].full_swing, drv_ctrl[0].cmos_low_drive}, 0);
        bus(1'b0, CKOD_OUT0_ADDR, 32'h0);
        check(rd, 32'h42);
    endtask : t_off_swing
    task t_source;
        bus(1'b1, CKOD_SRC_ADDR, 32'h80);
        check(clk_source, SRC_PLL_REFERENCE);
        bus(1'b0, CKOD_SRC_ADDR, 32'h0);
        check(rd, 32'h80);
        bus(1'b1, CKOD_SRC_ADDR, 32'h0);
        check(clk_source, SRC_SHARED_DIVIDER);
        bus(1'b1, 32'h100, 32'hff);
        bus(1'b0, 32'h100, 32'h0);
        check(rd, 32'h0);
    endtask : t_source
    task t_rereset;
        bus(1'b1, CKOD_SRC_ADDR, 32'h80);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        check(drv_ctrl[0], CKOD_CTRL_RESET);
        check(drv_ctrl[1], CKOD_CTRL_RESET);
        check(clk_source, SRC_SHARED_DIVIDER);
        bus(1'b0, CKOD_OUT0_ADDR, 32'h0);
        check(rd, 32'hc1);
    endtask : t_rereset

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        t_reset();
        t_formats();
        t_polarity();
        t_off_swing();
        t_source();
        t_rereset();
        give_verdict();
    end
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule : ckod_top_tb
